// ---- rtl/smc_pkg.sv ----
package smc_pkg;

   // ------------------------------------------------------------------
   // Register map (byte addresses on the APB bus)
   // ------------------------------------------------------------------
   localparam logic [7:0] SMC_SYSCTL_OFF = 8'h00;
   localparam logic [7:0] SMC_DIVCTL_OFF = 8'h04;
   localparam logic [7:0] SMC_CMD_OFF = 8'h08;
   localparam logic [7:0] SMC_STATUS_OFF = 8'h0c;

   // ------------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------------
   localparam int SMC_DEEP_SEL_BIT = 7;
   localparam int SMC_STS_LSB = 4;
   localparam int SMC_NMI_EDGE_BIT = 2;
   localparam int SMC_MEM_EN_BIT = 0;
   localparam logic [7:0] SMC_SYSCTL_RST = 8'h0b;
   localparam logic [1:0] SMC_DIV_RST = 2'h0;
   localparam int SMC_CMD_SLEEP_BIT = 0;
   localparam logic [1:0] SMC_REFRESH_INIT_MASK = 2'h3;

   // ------------------------------------------------------------------
   // Settle wait lengths in states of the divided clock
   // ------------------------------------------------------------------
   localparam int SMC_WAIT_W = 18;
   localparam logic [17:0] SMC_WAIT_8K = 18'h02000;
   localparam logic [17:0] SMC_WAIT_16K = 18'h04000;
   localparam logic [17:0] SMC_WAIT_32K = 18'h08000;
   localparam logic [17:0] SMC_WAIT_64K = 18'h10000;
   localparam logic [17:0] SMC_WAIT_128K = 18'h20000;
   localparam logic [17:0] SMC_WAIT_1K = 18'h00400;

   // Operating states, Gray coded along run -> standby -> settle.
   typedef enum logic [2:0] {
      SMC_RUN = 3'h0,
      SMC_SLEEP = 3'h4,
      SMC_SW_STANDBY_PIN = 3'h1,
      SMC_SETTLE = 3'h3,
      SMC_RST_HOLD = 3'h2,
      SMC_HW_STANDBY_PIN = 3'h6,
      SMC_HW_OSC = 3'h7
   } smc_state_e;

   // Controls handed to the rest of the chip.
   typedef struct packed {
      logic cpu_halt;
      logic clock_run;
      logic osc_run;
      logic periph_halt;
      logic periph_reset;
      logic dma_reset;
      logic chip_reset;
      logic refresh_init;
      logic port_hiz;
      logic irq_exception;
      logic reset_exception;
   } smc_ctl_s;

endpackage

// ---- rtl/smc_controller.sv ----
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module smc_controller
   import smc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleep_exec,
   input wire logic nmi_pin,
   input wire logic [2:0] ext_req_n,
   input wire logic [2:0] ext_req_en,
   input wire logic [2:0] ext_req_masked,
   input wire logic chip_init_pin_n,
   input wire logic standby_pin_n,
   output smc_ctl_s ctl,
   output logic onchip_memory_enable
);

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [5:0] pin_s1_q;
   logic [5:0] pin_s2_q;
   logic nmi_prev_q;
   logic nmi_s;
   logic init_n_s;
   logic standby_pin_n_s;
   logic [2:0] req_n_s;

   // Two flops per pin; the first stage feeds nothing but the second.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_q <= 6'h3f;
         pin_s2_q <= 6'h3f;
      end else begin
         pin_s1_q <= {nmi_pin, ext_req_n, chip_init_pin_n, standby_pin_n};
         pin_s2_q <= pin_s1_q;
      end
   end

   assign nmi_s = pin_s2_q[5];
   assign req_n_s = pin_s2_q[4:2];
   assign init_n_s = pin_s2_q[1];
   assign standby_pin_n_s = pin_s2_q[0];

   // Edge history of the synchronised NMI.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_prev_q <= 1'b1;
      end else begin
         nmi_prev_q <= nmi_s;
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   logic deep_standby_select_q;
   logic [2:0] settle_sel_q;
   logic nonmaskable_edge_select_q;
   logic mem_en_q;
   logic [1:0] div_q;
   logic wr_en;
   logic sleep_cmd;
   smc_state_e state_q;
   smc_state_e state_d;

   assign wr_en = psel && penable && pwrite && pstrb[0];
   assign sleep_cmd = sleep_exec
      || (wr_en && paddr == SMC_CMD_OFF && pwdata[SMC_CMD_SLEEP_BIT]);

   // System control bits; deep select survives an interrupt wake.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         deep_standby_select_q <= SMC_SYSCTL_RST[SMC_DEEP_SEL_BIT];
         settle_sel_q <= SMC_SYSCTL_RST[SMC_STS_LSB +: 3];
         nonmaskable_edge_select_q <= SMC_SYSCTL_RST[SMC_NMI_EDGE_BIT];
         mem_en_q <= SMC_SYSCTL_RST[SMC_MEM_EN_BIT];
      end else if (state_q == SMC_HW_STANDBY_PIN) begin
         // Hardware standby resets everything except the RAM array.
         deep_standby_select_q <= SMC_SYSCTL_RST[SMC_DEEP_SEL_BIT];
         settle_sel_q <= SMC_SYSCTL_RST[SMC_STS_LSB +: 3];
         nonmaskable_edge_select_q <= SMC_SYSCTL_RST[SMC_NMI_EDGE_BIT];
         mem_en_q <= SMC_SYSCTL_RST[SMC_MEM_EN_BIT];
      end else if (wr_en && paddr == SMC_SYSCTL_OFF) begin
         deep_standby_select_q <= pwdata[SMC_DEEP_SEL_BIT];
         settle_sel_q <= pwdata[SMC_STS_LSB +: 3];
         nonmaskable_edge_select_q <= pwdata[SMC_NMI_EDGE_BIT];
         mem_en_q <= pwdata[SMC_MEM_EN_BIT];
      end
   end

   // Clock divide setting.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= SMC_DIV_RST;
      end else if (state_q == SMC_HW_STANDBY_PIN) begin
         div_q <= SMC_DIV_RST;
      end else if (wr_en && paddr == SMC_DIVCTL_OFF) begin
         div_q <= pwdata[1:0];
      end
   end

   assign onchip_memory_enable = mem_en_q;

   // ------------------------------------------------------------------
   // APB read side
   // ------------------------------------------------------------------
   assign pready = 1'b1;
   assign pslverr = psel && penable && (paddr[7:4] != 4'h0 || paddr[1:0] != 2'h0);

   // Read data is registered from the setup phase so it is stable in access.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            SMC_SYSCTL_OFF: prdata <= {24'h0, deep_standby_select_q, settle_sel_q,
               1'b1, nonmaskable_edge_select_q, 1'b1, mem_en_q};
            SMC_DIVCTL_OFF: prdata <= {30'h0, div_q};
            SMC_STATUS_OFF: prdata <= {29'h0, state_q};
            default: prdata <= 32'h0;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Settle wait: counts states of the divided clock
   // ------------------------------------------------------------------
   function automatic logic [17:0] smc_wait_len(input logic [2:0] sel);
      case (sel)
         3'h0: smc_wait_len = SMC_WAIT_8K;
         3'h1: smc_wait_len = SMC_WAIT_16K;
         3'h2: smc_wait_len = SMC_WAIT_32K;
         3'h3: smc_wait_len = SMC_WAIT_64K;
         3'h4: smc_wait_len = SMC_WAIT_128K;
         3'h5: smc_wait_len = SMC_WAIT_1K;
         // Illegal patterns fall back to the longest wait, the safe side.
         default: smc_wait_len = SMC_WAIT_128K;
      endcase
   endfunction

   logic [2:0] div_cnt_q;
   logic state_tick;
   logic [17:0] wait_q;

   // Prescaler giving one enable per 1, 2, 4 or 8 clocks.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_q <= 3'h0;
      end else if (state_q != SMC_SETTLE) begin
         div_cnt_q <= 3'h0;
      end else begin
         div_cnt_q <= div_cnt_q + 3'h1;
      end
   end

   always_comb begin
      case (div_q)
         2'h0: state_tick = 1'b1;
         2'h1: state_tick = div_cnt_q[0];
         2'h2: state_tick = &div_cnt_q[1:0];
         default: state_tick = &div_cnt_q;
      endcase
   end

   // Wait counter, loaded on entry to the settle phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_q <= 18'h0;
      end else if (state_q != SMC_SETTLE) begin
         wait_q <= smc_wait_len(settle_sel_q);
      end else if (state_tick && wait_q != 18'h0) begin
         wait_q <= wait_q - 18'h1;
      end
   end

   // ------------------------------------------------------------------
   // Wake sources
   // ------------------------------------------------------------------
   logic nmi_edge;
   logic req_wake;
   logic wake;

   // Selected NMI edge, then the enabled and unmasked request lines only.
   assign nmi_edge = nonmaskable_edge_select_q ? (nmi_s && !nmi_prev_q)
                                               : (!nmi_s && nmi_prev_q);
   assign req_wake = |(~req_n_s & ext_req_en & ~ext_req_masked);
   assign wake = nmi_edge || req_wake;

   // ------------------------------------------------------------------
   // State machine
   // ------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         SMC_RUN: begin
            if (sleep_cmd) begin
               state_d = deep_standby_select_q ? SMC_SW_STANDBY_PIN : SMC_SLEEP;
            end
         end
         SMC_SLEEP: begin
            if (wake) begin
               state_d = SMC_RUN;
            end
         end
         SMC_SW_STANDBY_PIN: begin
            if (!init_n_s) begin
               state_d = SMC_RST_HOLD;
            end else if (wake) begin
               state_d = SMC_SETTLE;
            end
         end
         SMC_SETTLE: begin
            if (wait_q == 18'h0) begin
               state_d = SMC_RUN;
            end
         end
         SMC_RST_HOLD: begin
            if (init_n_s) begin
               state_d = SMC_RUN;
            end
         end
         SMC_HW_STANDBY_PIN: begin
            state_d = SMC_HW_OSC;
         end
         SMC_HW_OSC: begin
            if (init_n_s) begin
               state_d = SMC_RUN;
            end
         end
         default: state_d = SMC_RUN;
      endcase
      // The standby pin wins from any state; leaving needs it high.
      if (!standby_pin_n_s) begin
         state_d = SMC_HW_STANDBY_PIN;
      end else if (state_q == SMC_HW_STANDBY_PIN) begin
         state_d = SMC_HW_OSC;
      end
      // Reset low outside standby holds the chip in reset.
      if (standby_pin_n_s && !init_n_s && (state_q == SMC_RUN || state_q == SMC_SLEEP
            || state_q == SMC_SETTLE)) begin
         state_d = SMC_RST_HOLD;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= SMC_RST_HOLD;
      end else begin
         state_q <= state_d;
      end
   end

   // Exception requests fire once when leaving settle, reset hold or the oscillator wait after hardware standby.
   logic irq_exc_q;
   logic rst_exc_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_exc_q <= 1'b0;
         rst_exc_q <= 1'b0;
      end else begin
         irq_exc_q <= state_q == SMC_SETTLE && state_d == SMC_RUN;
         rst_exc_q <= (state_q == SMC_RST_HOLD || state_q == SMC_HW_OSC)
            && state_d == SMC_RUN;
      end
   end

   // ------------------------------------------------------------------
   // Chip controls
   // ------------------------------------------------------------------
   logic sw_standby_pin;
   logic hw_standby_pin;
   logic sw_entry_q;

   assign sw_standby_pin = state_q == SMC_SW_STANDBY_PIN || state_q == SMC_SETTLE;
   assign hw_standby_pin = state_q == SMC_HW_STANDBY_PIN;

   // Refresh init is a one-shot on entry, other refresh bits hold.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_entry_q <= 1'b0;
      end else begin
         sw_entry_q <= state_q != SMC_SW_STANDBY_PIN && state_d == SMC_SW_STANDBY_PIN;
      end
   end

   // CPU state, RAM and port settings are untouched in software standby:
   // nothing here resets them, and port_hiz stays low so pins keep driving.
   always_comb begin
      ctl.cpu_halt = state_q != SMC_RUN;
      ctl.clock_run = !(state_q == SMC_SW_STANDBY_PIN || hw_standby_pin);
      ctl.osc_run = state_q != SMC_SW_STANDBY_PIN && !hw_standby_pin;
      ctl.periph_halt = sw_standby_pin || hw_standby_pin;
      ctl.periph_reset = sw_standby_pin || hw_standby_pin || state_q == SMC_HW_OSC;
      ctl.dma_reset = sw_standby_pin || hw_standby_pin || state_q == SMC_HW_OSC;
      ctl.chip_reset = hw_standby_pin || state_q == SMC_HW_OSC
         || state_q == SMC_RST_HOLD;
      ctl.refresh_init = sw_entry_q && (SMC_REFRESH_INIT_MASK != 2'h0);
      ctl.port_hiz = hw_standby_pin;
      ctl.irq_exception = irq_exc_q;
      ctl.reset_exception = rst_exc_q;
   end

endmodule // smc_controller

// ---- bench/smc_controller_monitor.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Port-level checks
// ------------------------------------------------------------------
module smc_controller_monitor
   import smc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic chip_init_pin_n,
   input wire logic standby_pin_n,
   input wire smc_ctl_s ctl
);
   // All checks share the bus clock and the bus reset.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_ready_high: assert property (psel |-> pready)
      else $error("pready low during a transfer.");
   a_bad_addr: assert property (psel && penable && paddr[7:4] != 4'h0 |-> pslverr)
      else $error("Unmapped access not flagged.");
   a_standby_pin_entry: assert property ($fell(standby_pin_n) |-> ##[1:5] ctl.port_hiz)
      else $error("Standby pin low did not float the ports.");
   a_hw_float: assert property ((!standby_pin_n)[*6] |-> ctl.port_hiz && ctl.cpu_halt && ctl.chip_reset)
      else $error("Hardware standby controls wrong.");
   a_sw_halt: assert property (ctl.refresh_init |-> ctl.cpu_halt && !ctl.clock_run && ctl.periph_reset && ctl.dma_reset && !ctl.port_hiz)
      else $error("Software standby controls wrong.");
   // The halted, clockless, driven, unreset mix is only seen in software standby.
   a_refresh_entry: assert property ($rose(ctl.cpu_halt && !ctl.clock_run && !ctl.port_hiz
      && !ctl.chip_reset) |-> ctl.refresh_init && ctl.periph_halt)
      else $error("Software standby entry without refresh init or peripheral halt.");
   a_refresh_once: assert property (ctl.refresh_init |=> !ctl.refresh_init)
      else $error("Refresh init longer than one cycle.");
   a_irq_clocked: assert property (ctl.irq_exception |-> ctl.osc_run && ctl.clock_run ##1 !ctl.irq_exception)
      else $error("Interrupt start without running clock.");
   a_rst_clock: assert property ((!chip_init_pin_n && standby_pin_n)[*6] |-> ctl.chip_reset && ctl.osc_run)
      else $error("Reset pin low without oscillator.");
endmodule // smc_controller_monitor

// ---- bench/smc_pin_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Board-side reset and standby pins
// ------------------------------------------------------------------
module smc_pin_model (
   input wire logic pclk,
   output logic chip_init_pin_n,
   output logic standby_pin_n
);
   // Oscillator settle allowance kept by the board before reset rises.
   localparam int SETTLE = 20;
   // Both pins idle high from time zero.
   initial begin
      chip_init_pin_n = 1'b1;
      standby_pin_n = 1'b1;
   end
   task drive(input logic r, input logic s);
      @(posedge pclk);
      chip_init_pin_n <= r;
      standby_pin_n <= s;
   endtask
   // Reset goes low before standby, so the core never sees a live stop.
   // The mode pins are not modelled here, so nothing moves them in standby.
   task hw_enter();
      drive(1'b0, 1'b1);
      drive(1'b0, 1'b0);
   endtask
   // Reset stays low until the oscillator has had time to settle.
   task hw_exit();
      drive(1'b0, 1'b1);
      repeat (SETTLE) @(posedge pclk);
      drive(1'b1, 1'b1);
   endtask
endmodule // smc_pin_model

// ---- bench/smc_controller_tb.sv ----
`timescale 1ns/1ps
module smc_controller_tb;
   import smc_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic sleep_exec = 1'b0, nmi_pin = 1'b0, pready, pslverr, err, mem_en;
   logic chip_init_pin_n, standby_pin_n;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, got;
   logic [3:0] pstrb = 4'hf;
   logic [2:0] ext_req_n = 3'h7, ext_req_en = 3'h7, ext_req_masked = 3'h0;
   smc_ctl_s ctl;
   int fails = 0, n_checks = 0, n;

   // Free-running 100 MHz bus clock.
   always #5 pclk = ~pclk;

   smc_pin_model pins (.pclk(pclk), .chip_init_pin_n(chip_init_pin_n),
      .standby_pin_n(standby_pin_n));
   smc_controller uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sleep_exec(sleep_exec), .nmi_pin(nmi_pin),
      .ext_req_n(ext_req_n), .ext_req_en(ext_req_en), .ext_req_masked(ext_req_masked),
      .chip_init_pin_n(chip_init_pin_n), .standby_pin_n(standby_pin_n), .ctl(ctl),
      .onchip_memory_enable(mem_en));

   // ------------------------------------------------------------------
   // Shared helpers
   // ------------------------------------------------------------------
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s exp %h got %h", nm, exp, seen);
      end
   endtask
   // One APB transfer; read data and error are taken at the ready edge.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      got = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task stat(input logic [31:0] e);
      apb(1'b0, SMC_STATUS_OFF, 32'h0);
      chk("status", got, e);
   endtask
   function logic pick(input int k);
      case (k)
         0: return ctl.irq_exception;
         1: return ctl.reset_exception;
         default: return ctl.port_hiz;
      endcase
   endfunction
   // Sampling on the falling edge keeps clear of the flop updates.
   task wfor(input int k);
      n = 0;
      while (pick(k) !== 1'b1 && n < 9000) begin
         @(negedge pclk);
         n++;
      end
      chk("event", {31'h0, pick(k)}, 32'h1);
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task sw_wake(input logic [2:0] sts, input logic [1:0] div, input int src, input int lo);
      // The bench stands for an external clock, so short settle selects are legal.
      apb(1'b1, SMC_SYSCTL_OFF, {24'h0, 1'b1, sts, 4'hf});
      apb(1'b1, SMC_DIVCTL_OFF, {30'h0, div});
      if (src == 2) begin
         sleep_exec <= 1'b1;
         @(posedge pclk);
         sleep_exec <= 1'b0;
      end else
         apb(1'b1, SMC_CMD_OFF, 32'h1);
      stat(32'h1);
      ext_req_en <= 3'h6;
      ext_req_masked <= 3'h2;
      ext_req_n <= 3'h4;
      repeat (8) @(negedge pclk);
      stat(32'h1);
      if (src == 1)
         ext_req_n <= 3'h3;
      else
         nmi_pin <= 1'b1;
      wfor(0);
      chk("settle", {31'h0, n >= lo && n <= lo + 12}, 32'h1);
      nmi_pin <= 1'b0;
      ext_req_n <= 3'h7;
      apb(1'b0, SMC_SYSCTL_OFF, 32'h0);
      chk("deep_sel", {31'h0, got[7]}, 32'h1);
   endtask
   task sleep_and_reset();
      apb(1'b1, SMC_SYSCTL_OFF, 32'h0f);
      apb(1'b1, SMC_CMD_OFF, 32'h1);
      stat(32'h4);
      nmi_pin <= 1'b1;
      repeat (6) @(negedge pclk);
      nmi_pin <= 1'b0;
      stat(32'h0);
      apb(1'b1, SMC_SYSCTL_OFF, 32'hdf);
      apb(1'b1, SMC_CMD_OFF, 32'h1);
      pins.drive(1'b0, 1'b1);
      repeat (6) @(negedge pclk);
      stat(32'h2);
      pins.drive(1'b1, 1'b1);
      wfor(1);
      chk("rst_exc", {31'h0, n < 20}, 32'h1);
   endtask
   task hw_standby();
      apb(1'b1, SMC_SYSCTL_OFF, 32'h0e);
      @(negedge pclk);
      chk("mem_en", {31'h0, mem_en}, 32'h0);
      pins.hw_enter();
      wfor(2);
      stat(32'h6);
      chk("halt", {31'h0, ctl.cpu_halt & ctl.port_hiz}, 32'h1);
      pins.drive(1'b0, 1'b1);
      repeat (6) @(negedge pclk);
      stat(32'h7);
      pins.drive(1'b1, 1'b1);
      wfor(1);
      apb(1'b0, SMC_SYSCTL_OFF, 32'h0);
      chk("sysctl", got, 32'h0b);
      chk("mem_en_rst", {31'h0, mem_en}, 32'h1);
      apb(1'b1, SMC_SYSCTL_OFF, 32'hde);
      apb(1'b1, SMC_CMD_OFF, 32'h1);
      pins.drive(1'b1, 1'b0);
      wfor(2);
      chk("sw_to_hw", {31'h0, n < 8}, 32'h1);
      pins.drive(1'b0, 1'b0);
      pins.hw_exit();
      wfor(1);
      stat(32'h0);
   endtask

   // ------------------------------------------------------------------
   // Main sequence, verdict and watchdog
   // ------------------------------------------------------------------
   task wrap_up();
      if (fails == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, SMC_SYSCTL_OFF, 32'h0);
      chk("sysctl", got, 32'h0b);
      stat(32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", {got[30:0], err}, 32'h1);
      sw_wake(3'h5, 2'h0, 0, 1024);
      sw_wake(3'h5, 2'h1, 1, 2048);
      sw_wake(3'h0, 2'h0, 2, 8192);
      sleep_and_reset();
      hw_standby();
      wrap_up();
   end
   // The tests need about 11500 cycles; three and a half times that means a hang.
   initial begin
      repeat (40000) @(posedge pclk);
      fails++;
      wrap_up();
   end
endmodule // smc_controller_tb

bind smc_controller smc_controller_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .chip_init_pin_n(chip_init_pin_n), .standby_pin_n(standby_pin_n), .ctl(ctl));
